// *** host_model.sv ***
// Behavioural microprocessor master driving the muxed host bus
`timescale 1ns/100ps
module host_model (
  // Clock and strap level
  input wire logic core_clk,
  input wire logic style,
  // Bus level as seen on the pins
  input wire logic [7:0] bus_level,
  // Host strobes
  output logic chip_sel_n,
  output logic address_strobe,
  output logic data_strobe,
  output logic read_write_n,
  // Host side of the data lines
  output logic [7:0] host_data,
  output logic host_oe
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Deselected, strobes parked, bus released
  initial
  begin
    chip_sel_n = 1'b1;
    address_strobe = 1'b0;
    data_strobe = 1'b0;
    read_write_n = 1'b1;
    host_data = 8'h00;
    host_oe = 1'b0;
  end

  // Park data strobe inactive for the current strap
  task automatic park();
    @(posedge core_clk);
    data_strobe <= ~style;
    read_write_n <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // strobe before access
  task automatic addr_phase(input logic sel, input logic [7:0] a);
    @(posedge core_clk);
    chip_sel_n <= ~sel;
    address_strobe <= 1'b1;
    host_data <= a;
    host_oe <= 1'b1;
    @(posedge core_clk);
    address_strobe <= 1'b0;
  endtask

  // Data phase; read byte taken at the last strobe edge
  // late data strobe
  task automatic data_phase(input logic sel, input logic wr, input logic [7:0] d,
                            output logic [7:0] rd);
    @(posedge core_clk);
    chip_sel_n <= ~sel;
    host_data <= d;
    // Release the lines for reads so the port can drive
    host_oe <= wr;
    read_write_n <= ~wr;
    data_strobe <= style ? 1'b1 : wr;
    repeat (4) @(posedge core_clk);
    rd = bus_level;
    data_strobe <= ~style;
    read_write_n <= 1'b1;
    @(posedge core_clk);
    chip_sel_n <= 1'b1;
    host_oe <= 1'b0;
  endtask
endmodule // host_model

// *** muxed_bus_pkg.sv ***
// Constants, state codes and helpers for the muxed host bus port
//
// What this block does
// [RL1] Host drives chip select low per cycle
// [RL2] Host holds chip select across all strobes
// [RL3] Unselected cycles latch address, never access
// [RL4] Power fail forces chip select inactive
// [RL5] Address captured at address strobe fall
// [RL6] Address strobe rise discards held address
// [RL7] Host strobes address before every access
// [RL8] Unselected access needs fresh address strobe
// [RL9] Strobe style: read/write is level
// [RL10] Enable style: write data on rise
// [RL11] Host pulses data strobe late in cycle
// [RL12] Strobe style reads drive bus while strobe
// [RL13] Strobe style writes capture on strobe fall
// [RL14] Enable style: drive only while enabled
// [RL15] Strap high strobe style, low enable
// [RL16] Host presents address first, then data
// [RL17] Read ends, bus floats at strobe end
// [RL18] One internal request per qualified access
package muxed_bus_pkg;

  // -------------------------------------------------------------------
  // Widths and reset values
  // -------------------------------------------------------------------
  localparam int BUS_W = 8;                      // Byte-wide muxed bus
  localparam int PIN_W = 3;                      // Number of strobe pins watched
  localparam logic [BUS_W-1:0] BUS_RST = 8'h00;  // Reset value of held bytes
  localparam logic [PIN_W-1:0] PIN_RST = 3'h0;   // Reset value of pin history

  // -------------------------------------------------------------------
  // Strobe vector bit positions
  // -------------------------------------------------------------------
  localparam int IDX_ADDR_STROBE = 0; // Address strobe
  localparam int IDX_DATA_STROBE = 1; // Data strobe
  localparam int IDX_RW = 2; // Read/write line

  // -------------------------------------------------------------------
  // Bus style codes, as seen on the strap
  // -------------------------------------------------------------------
  localparam logic STYLE_STROBE = 1'b1; // Data-strobe style
  localparam logic STYLE_ENABLE = 1'b0; // Enable style, pulldown default

  // -------------------------------------------------------------------
  // Port phase
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, // No address held
    ST_ADDR = 2'h1, // Address held, waiting for data phase
    ST_READ = 2'h2  // Driving read data
  } port_state_e;

  // Read window level for either style
  function automatic logic read_level(input logic style, input logic strobe, input logic rw);
    read_level = (style == STYLE_STROBE) ? (strobe & rw) : (~strobe & rw);
  endfunction

endpackage

// *** muxed_bus_port.sv ***
// Device-side muxed address/data host bus port
`timescale 1ns/100ps
module muxed_bus_port #(
  parameter int BUS_W = muxed_bus_pkg::BUS_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Host bus pins
  input wire logic chip_sel_n,
  input wire logic address_strobe,
  input wire logic data_strobe,
  input wire logic read_write_n,
  input wire logic bus_style_select,
  input wire logic [BUS_W-1:0] muxed_addr_data_in,
  output logic [BUS_W-1:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe,
  // Supply monitor
  input wire logic below_power_fail_threshold,
  // Request toward the register and RAM bank
  output logic req_valid,
  output logic req_write,
  output logic [BUS_W-1:0] req_addr,
  output logic [BUS_W-1:0] req_wdata,
  input wire logic [BUS_W-1:0] bank_rdata
);

  // -------------------------------------------------------------------
  // Elaboration check
  // -------------------------------------------------------------------
  if (BUS_W != muxed_bus_pkg::BUS_W)
  begin : g_chk
    $error("muxed_bus_port serves only the byte-wide bus");
  end

  // -------------------------------------------------------------------
  // Pin history and edges
  // -------------------------------------------------------------------
  logic [muxed_bus_pkg::PIN_W-1:0] pins;   // Strobe pins as a vector
  logic [muxed_bus_pkg::PIN_W-1:0] pins_q; // Last sample of strobes
  logic [muxed_bus_pkg::PIN_W-1:0] rise;   // Rising edges
  logic [muxed_bus_pkg::PIN_W-1:0] fall;   // Falling edges

  assign pins[muxed_bus_pkg::IDX_ADDR_STROBE] = address_strobe;
  assign pins[muxed_bus_pkg::IDX_DATA_STROBE] = data_strobe;
  assign pins[muxed_bus_pkg::IDX_RW] = read_write_n;

  strobe_edges #(
    .W(muxed_bus_pkg::PIN_W)
  ) u_edges (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .level(pins),
    .prev_q(pins_q),
    .rise(rise),
    .fall(fall)
  );

  // -------------------------------------------------------------------
  // Style strap and bus history
  // -------------------------------------------------------------------
  logic style_q;                // Sampled strap
  logic style_d;                // Next strap sample
  logic [BUS_W-1:0] bus_prev_q; // Bus byte one cycle back
  logic [BUS_W-1:0] bus_prev_d; // Next bus history

  // Strap follows the pin; reset value is the pulldown choice
  always_comb
  begin
    // [RL15] strap picks style
    style_d = bus_style_select;
    bus_prev_d = muxed_addr_data_in;
  end

  // Strap is caught by the clock, never by the reset itself
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      style_q <= muxed_bus_pkg::STYLE_ENABLE;
      bus_prev_q <= muxed_bus_pkg::BUS_RST;
    end
    else
    begin
      style_q <= style_d;
      bus_prev_q <= bus_prev_d;
    end
  end

  // -------------------------------------------------------------------
  // Access qualification
  // -------------------------------------------------------------------
  logic cs_ok;       // Chip select active and supply good
  logic addr_rise;   // Address strobe rising
  logic addr_fall;   // Address strobe falling
  logic window_open; // Read data may be driven now
  logic write_edge;  // Write data capture edge
  logic data_end;    // Data phase has finished

  // [RL4] power fail blocks select
  assign cs_ok = ~chip_sel_n & ~below_power_fail_threshold;
  assign addr_rise = rise[muxed_bus_pkg::IDX_ADDR_STROBE];
  assign addr_fall = fall[muxed_bus_pkg::IDX_ADDR_STROBE];
  // [RL9] read level per style
  assign window_open = cs_ok & muxed_bus_pkg::read_level(style_q, data_strobe, read_write_n);
  // [RL13] strobe fall with write level; [RL10] enable-style rise
  assign write_edge = (style_q == muxed_bus_pkg::STYLE_STROBE)
                    ? (fall[muxed_bus_pkg::IDX_DATA_STROBE] & ~pins_q[muxed_bus_pkg::IDX_RW])
                    : rise[muxed_bus_pkg::IDX_RW];
  // [RL17] strobe end closes the phase
  assign data_end = (style_q == muxed_bus_pkg::STYLE_STROBE)
                  ? fall[muxed_bus_pkg::IDX_DATA_STROBE]
                  : (rise[muxed_bus_pkg::IDX_DATA_STROBE] | rise[muxed_bus_pkg::IDX_RW]);

  // -------------------------------------------------------------------
  // Port phase, held address and request
  // -------------------------------------------------------------------
  muxed_bus_pkg::port_state_e state_q; // Current phase
  muxed_bus_pkg::port_state_e state_d; // Next phase
  logic [BUS_W-1:0] addr_q;            // Held address
  logic [BUS_W-1:0] addr_d;            // Next held address
  logic req_valid_q;                   // Request pulse
  logic req_valid_d;                   // Next request pulse
  logic req_write_q;                   // Request direction
  logic req_write_d;                   // Next direction
  logic [BUS_W-1:0] req_addr_q;        // Request address
  logic [BUS_W-1:0] req_addr_d;        // Next request address
  logic [BUS_W-1:0] req_wdata_q;       // Request write data
  logic [BUS_W-1:0] req_wdata_d;       // Next write data
  logic [BUS_W-1:0] rdata_q;           // Read byte on the bus
  logic [BUS_W-1:0] rdata_d;           // Next read byte
  logic oe_q;                          // Bus drive enable
  logic oe_d;                          // Next drive enable

  // Next phase; address strobe edges win over any data event
  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    req_valid_d = 1'b0;
    req_write_d = req_write_q;
    req_addr_d = req_addr_q;
    req_wdata_d = req_wdata_q;
    rdata_d = rdata_q;
    if (addr_rise)
    begin
      // [RL6] drop held address
      state_d = muxed_bus_pkg::ST_IDLE;
    end
    else if (addr_fall)
    begin
      // [RL5] latch address at fall
      addr_d = bus_prev_q;
      state_d = muxed_bus_pkg::ST_ADDR;
    end
    else
    begin
      unique case (state_q)
        // Without a held address nothing may happen
        muxed_bus_pkg::ST_IDLE:
        begin
          state_d = muxed_bus_pkg::ST_IDLE;
        end
        // Held address, waiting for the data phase
        muxed_bus_pkg::ST_ADDR:
        begin
          if (window_open)
          begin
            // [RL18] one read request
            state_d = muxed_bus_pkg::ST_READ;
            req_valid_d = 1'b1;
            req_write_d = 1'b0;
            req_addr_d = addr_q;
          end
          else if (write_edge)
          begin
            // Address is used up even when unselected
            state_d = muxed_bus_pkg::ST_IDLE;
            // [RL3] unselected cycle does nothing
            if (cs_ok)
            begin
              // [RL18] one write request
              req_valid_d = 1'b1;
              req_write_d = 1'b1;
              req_addr_d = addr_q;
              req_wdata_d = bus_prev_q;
            end
          end
          else if (data_end)
          begin
            // Unselected read still consumes the address
            state_d = muxed_bus_pkg::ST_IDLE;
          end
        end
        // Driving read data until the window closes
        muxed_bus_pkg::ST_READ:
        begin
          // [RL17] end read, float bus
          if (!window_open || data_end)
            state_d = muxed_bus_pkg::ST_IDLE;
          else
            rdata_d = bank_rdata;
        end
        // Unused code falls back to idle
        default:
        begin
          state_d = muxed_bus_pkg::ST_IDLE;
        end
      endcase
    end
    // [RL12] [RL14] drive only in read phase
    oe_d = (state_d == muxed_bus_pkg::ST_READ);
  end

  // Register the phase group
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= muxed_bus_pkg::ST_IDLE;
      addr_q <= muxed_bus_pkg::BUS_RST;
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_addr_q <= muxed_bus_pkg::BUS_RST;
      req_wdata_q <= muxed_bus_pkg::BUS_RST;
      rdata_q <= muxed_bus_pkg::BUS_RST;
      oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      req_valid_q <= req_valid_d;
      req_write_q <= req_write_d;
      req_addr_q <= req_addr_d;
      req_wdata_q <= req_wdata_d;
      rdata_q <= rdata_d;
      oe_q <= oe_d;
    end
  end

  // Outputs come straight from flops
  assign muxed_addr_data_out = rdata_q;
  assign muxed_addr_data_oe = oe_q;
  assign req_valid = req_valid_q;
  assign req_write = req_write_q;
  assign req_addr = req_addr_q;
  assign req_wdata = req_wdata_q;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_no_unselected_access; // [RL3]
    @(posedge core_clk) disable iff (!reset_n)
    req_valid_q |-> $past(cs_ok);
  endproperty
  a_no_unselected_access: assert property (p_no_unselected_access)
    else $error("request issued without chip select");

  property p_power_fail_blocks; // [RL4]
    @(posedge core_clk) disable iff (!reset_n)
    below_power_fail_threshold |=> !oe_q && !req_valid_q;
  endproperty
  a_power_fail_blocks: assert property (p_power_fail_blocks)
    else $error("access during power fail");

  property p_addr_latch; // [RL5]
    @(posedge core_clk) disable iff (!reset_n)
    addr_fall |=> (addr_q == $past(bus_prev_q)) && (state_q == muxed_bus_pkg::ST_ADDR);
  endproperty
  a_addr_latch: assert property (p_addr_latch)
    else $error("address not latched at strobe fall");

  property p_addr_clear; // [RL6]
    @(posedge core_clk) disable iff (!reset_n)
    addr_rise |=> (state_q == muxed_bus_pkg::ST_IDLE) && !oe_q ##1 !req_valid_q;
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("address kept after strobe rise");

  property p_drive_window; // [RL12]
    @(posedge core_clk) disable iff (!reset_n)
    oe_q |-> $past(window_open) && $past(state_q) != muxed_bus_pkg::ST_IDLE;
  endproperty
  a_drive_window: assert property (p_drive_window)
    else $error("bus driven outside read window");

  property p_strobe_write; // [RL13]
    @(posedge core_clk) disable iff (!reset_n)
    (style_q && fall[muxed_bus_pkg::IDX_DATA_STROBE] && !pins_q[muxed_bus_pkg::IDX_RW]
      && cs_ok && !address_strobe && !pins_q[muxed_bus_pkg::IDX_ADDR_STROBE]
      && state_q == muxed_bus_pkg::ST_ADDR && !window_open)
    |=> req_valid_q && req_write_q && req_wdata_q == $past(bus_prev_q)
        && req_addr_q == $past(addr_q);
  endproperty
  a_strobe_write: assert property (p_strobe_write)
    else $error("strobe-style write not captured");

  property p_enable_write; // [RL10]
    @(posedge core_clk) disable iff (!reset_n)
    (!style_q && rise[muxed_bus_pkg::IDX_RW] && cs_ok && !window_open
      && !address_strobe && !pins_q[muxed_bus_pkg::IDX_ADDR_STROBE]
      && state_q == muxed_bus_pkg::ST_ADDR)
    |=> req_valid_q && req_write_q && req_wdata_q == $past(bus_prev_q);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable-style write not captured");

  property p_enable_oe; // [RL14]
    @(posedge core_clk) disable iff (!reset_n)
    (oe_q && !$past(style_q)) |-> !$past(data_strobe) && $past(read_write_n);
  endproperty
  a_enable_oe: assert property (p_enable_oe)
    else $error("enable-style drive without output enable");

  property p_read_end; // [RL17]
    @(posedge core_clk) disable iff (!reset_n)
    (state_q == muxed_bus_pkg::ST_READ && data_end) |=> !oe_q [*2];
  endproperty
  a_read_end: assert property (p_read_end)
    else $error("bus not floated after read end");

  property p_single_request; // [RL18]
    @(posedge core_clk) disable iff (!reset_n)
    req_valid_q |=> !req_valid_q;
  endproperty
  a_single_request: assert property (p_single_request)
    else $error("request longer than one cycle");

  property p_strap_follow; // [RL15]
    @(posedge core_clk) disable iff (!reset_n)
    ##1 style_q == $past(bus_style_select);
  endproperty
  a_strap_follow: assert property (p_strap_follow)
    else $error("style does not follow strap");

endmodule // muxed_bus_port

// *** strobe_edges.sv ***
// Edge detection for the host strobe pins
`timescale 1ns/100ps
module strobe_edges #(
  parameter int W = muxed_bus_pkg::PIN_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Pin levels, already synchronous
  input wire logic [W-1:0] level,
  // Last sampled level and edge pulses
  output logic [W-1:0] prev_q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // -------------------------------------------------------------------
  // Elaboration check
  // -------------------------------------------------------------------
  if (W < 1)
  begin : g_chk
    $error("strobe_edges needs at least one pin");
  end

  logic [W-1:0] prev_d; // Next history value

  // History just follows the pins
  always_comb
  begin
    prev_d = level;
  end

  // Register history; reset matches idle-low strobes
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_q <= W'(muxed_bus_pkg::PIN_RST);
    else
      prev_q <= prev_d;
  end

  // Edges compare pins now with last sample
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule // strobe_edges

// *** testbench.sv ***
// Self-checking bench for the muxed host bus port
`timescale 1ns/100ps
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk;
  logic reset_n;
  logic style; // Strap level
  logic pf; // Supply below threshold
  logic [7:0] bank_rdata;
  logic [7:0] bus_level; // Resolved data lines
  logic [7:0] bus_last; // Last level, inverted when nobody drives
  logic cs_n, addr_stb, data_stb, rw_n, host_oe;
  logic [7:0] host_data, dout, req_addr, req_wdata;
  logic oe, req_valid, req_write;
  int num_errors;
  int total_checks;
  int req_cnt; // Requests seen since clear
  int oe_cnt; // Cycles with the port driving
  logic cap_w;
  logic [7:0] cap_a, cap_d, rd;

  // Released lines never keep a stale value
  assign bus_level = oe ? dout : (host_oe ? host_data : ~bus_last);

  // ----------------------------------------------------------------
  // Clock, instances, monitor
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  muxed_bus_port i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .chip_sel_n(cs_n),
    .address_strobe(addr_stb), .data_strobe(data_stb), .read_write_n(rw_n),
    .bus_style_select(style), .muxed_addr_data_in(bus_level),
    .muxed_addr_data_out(dout), .muxed_addr_data_oe(oe),
    .below_power_fail_threshold(pf), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .bank_rdata(bank_rdata)
  );

  host_model i_host (
    .core_clk(core_clk), .style(style), .bus_level(bus_level), .chip_sel_n(cs_n),
    .address_strobe(addr_stb), .data_strobe(data_stb), .read_write_n(rw_n),
    .host_data(host_data), .host_oe(host_oe)
  );

  // Capture requests and count drive cycles
  always @(posedge core_clk)
  begin
    bus_last <= bus_level;
    if (req_valid === 1'b1)
    begin
      req_cnt++;
      cap_w = req_write;
      cap_a = req_addr;
      cap_d = req_wdata;
    end
    if (oe === 1'b1)
      oe_cnt++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Select strap, park strobes, clear counters
  task automatic setup(input logic s);
    @(posedge core_clk);
    style <= s;
    i_host.park();
    repeat (2) @(posedge core_clk);
    req_cnt = 0;
    oe_cnt = 0;
  endtask

  // Full access: address then data, then settle
  task automatic access(input logic sel, input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
    i_host.addr_phase(sel, a);
    i_host.data_phase(sel, wr, d, rd);
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Writes in both styles give one request each
  task automatic t_write();
    for (int s = 0; s < 2; s++)
    begin
      setup(s[0]);
      access(1'b1, 1'b1, 8'h3C ^ s[7:0], 8'hA5 ^ s[7:0]);
      `CHECK(req_cnt, 1)
      `CHECK(cap_w, 1'b1)
      `CHECK(cap_a, 8'h3C ^ s[7:0])
      `CHECK(cap_d, 8'hA5 ^ s[7:0])
      `CHECK(oe_cnt, 0)
    end
  endtask

  // Reads in both styles drive the bank byte, then float
  task automatic t_read();
    for (int s = 0; s < 2; s++)
    begin
      setup(s[0]);
      bank_rdata <= 8'h5A ^ s[7:0];
      access(1'b1, 1'b0, 8'h21 + s[7:0], 8'h00);
      `CHECK(rd, 8'h5A ^ s[7:0])
      `CHECK(req_cnt, 1)
      `CHECK(cap_w, 1'b0)
      `CHECK(cap_a, 8'h21 + s[7:0])
      `CHECK(oe, 1'b0)
      `CHECK(oe_cnt >= 3 && oe_cnt <= 5, 1'b1)
    end
  endtask

  // Unselected cycle consumes the address; only a fresh strobe reopens
  task automatic t_unselected();
    setup(1'b1);
    access(1'b0, 1'b1, 8'h40, 8'h11);
    `CHECK(req_cnt, 0)
    i_host.data_phase(1'b1, 1'b1, 8'h22, rd);
    repeat (3) @(posedge core_clk);
    `CHECK(req_cnt, 0)
    access(1'b1, 1'b1, 8'h41, 8'h33);
    `CHECK(req_cnt, 1)
    `CHECK(cap_a, 8'h41)
    `CHECK(cap_d, 8'h33)
  endtask

  // Second strobe replaces the first address
  task automatic t_restrobe();
    setup(1'b0);
    i_host.addr_phase(1'b1, 8'h50);
    access(1'b1, 1'b1, 8'h60, 8'h77);
    `CHECK(req_cnt, 1)
    `CHECK(cap_a, 8'h60)
    `CHECK(cap_d, 8'h77)
  endtask

  // Low supply blocks reads and writes in both styles
  task automatic t_power_fail();
    for (int s = 0; s < 2; s++)
    begin
      setup(s[0]);
      pf <= 1'b1;
      access(1'b1, 1'b1, 8'h0A, 8'hC3);
      access(1'b1, 1'b0, 8'h0B, 8'h00);
      `CHECK(req_cnt, 0)
      `CHECK(oe_cnt, 0)
      pf <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Verdict and run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the roughly 170 cycles the scenarios need
  initial
  begin
    #50000;
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    style = 1'b0;
    pf = 1'b0;
    bank_rdata = 8'h00;
    bus_last = 8'h00;
    num_errors = 0;
    total_checks = 0;
    req_cnt = 0;
    oe_cnt = 0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_write();
    t_read();
    t_unselected();
    t_restrobe();
    t_power_fail();
    end_sim();
  end
endmodule // testbench
